// file: design/trg_consts.svh
// Constants of the timeout reset guard: offsets, fields, resets.
// Assumes inclusion by bare name from the guard module and the testbench.
//
// Notes on behaviour
// - Nothing counts or resets before software enables.
// - Config bit one enables chip reset.
// - Config bit zero enables counting down.
// - Counting without trigger never resets the chip.
// - Prescaler count readable, advances each enabled clock.
// - Prescaler wraps to zero, decrements timeout counter.
// - Prescaler runs on oscillator clock, not PLL.
// - Wrap register divides by value plus one.
// - Timeout counter decrements per period, software-loadable.
// - Zero count with trigger issues chip reset.
// - Fired flag survives chip reset, power-on clears.
`ifndef TRG_CONSTS_SVH
`define TRG_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TRG_OFF_CFG 16'hF020
`define TRG_OFF_PRE 16'hF021
`define TRG_OFF_WRAP 16'hF022
`define TRG_OFF_CNT 16'hF023
`define TRG_OFF_STAT 16'hF024
`define TRG_OFF_ISTAT 16'hF025
`define TRG_OFF_IMASK 16'hF026

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRG_CFG_CNT_BIT 0
`define TRG_CFG_TRG_BIT 1
`define TRG_CFG_W 2
`define TRG_STAT_FIRED_BIT 0
`define TRG_EV_ZERO_BIT 0
`define TRG_EV_RST_BIT 1
`define TRG_EV_NUM 2

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define TRG_CFG_RST 2'h0
`define TRG_PRE_RST 16'h0000
`define TRG_WRAP_RST 16'hFFFF
`define TRG_CNT_RST 12'hFFF
`define TRG_PULSE_LEN 8'h10
`define TRG_DATA_ZERO 32'h0000_0000

`endif

// file: design/trg_pkg.sv
// Types of the timeout reset guard.
// Assumes the constants header beside it.
package trg_pkg;

  // ----------------------------------------
  // Guard state
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    TRG_ST_RUN = 2'h0,
    TRG_ST_HOLD = 2'h1
  } trg_state_e;

endpackage : trg_pkg

// file: design/trg_timeout_reset_guard.sv
// Timeout reset guard: prescaler, timeout counter, chip reset, irq.
// Assumes REF_CLK_I is the oscillator input and RST_I power-on reset.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "trg_consts.svh"

module trg_timeout_reset_guard
  import trg_pkg::*;
#(
  parameter int PRE_W = 16,
  parameter int CNT_W = 12,
  parameter int PULSE_W = 8
)
(
  // Clock, reset, enable
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Register port
  input wire logic [15:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Chip reset and interrupt
  output logic CHIP_RST_O,
  output logic IRQ_O
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction : hit

  logic [`TRG_CFG_W-1:0] cfg_q;
  logic [`TRG_CFG_W-1:0] cfg_d;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic [PRE_W-1:0] wrap_q;
  logic [PRE_W-1:0] wrap_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [PULSE_W-1:0] pulse_q;
  logic [PULSE_W-1:0] pulse_d;
  logic fired_q;
  logic fired_d;
  logic [`TRG_EV_NUM-1:0] ist_q;
  logic [`TRG_EV_NUM-1:0] ist_d;
  logic [`TRG_EV_NUM-1:0] imask_q;
  logic [`TRG_EV_NUM-1:0] imask_d;
  logic [`TRG_EV_NUM-1:0] ev;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] rd_mux;
  trg_state_e state_q;
  trg_state_e state_d;

  wire run = (state_q == TRG_ST_RUN);
  wire count_en = cfg_q[`TRG_CFG_CNT_BIT];
  wire trig_en = cfg_q[`TRG_CFG_TRG_BIT];
  wire wr_cfg = WR_I && hit(ADDR_I, `TRG_OFF_CFG);
  wire wr_wrap = WR_I && hit(ADDR_I, `TRG_OFF_WRAP);
  wire wr_cnt = WR_I && hit(ADDR_I, `TRG_OFF_CNT);
  wire wr_ist = WR_I && hit(ADDR_I, `TRG_OFF_ISTAT);
  wire wr_imask = WR_I && hit(ADDR_I, `TRG_OFF_IMASK);
  wire cnt_zero = (cnt_q == CNT_W'(0));
  wire pulse_done = (pulse_q == PULSE_W'(0));

  // ----------------------------------------
  // Prescaler and timeout counter
  // ----------------------------------------
  wire wrap_hit = run && count_en && (pre_q == wrap_q);
  wire fire = run && count_en && trig_en && cnt_zero;

  assign pre_d = !run ? PRE_W'(`TRG_PRE_RST)
               : !count_en ? pre_q
               : wrap_hit ? PRE_W'(0)
               : pre_q + PRE_W'(1);

  assign cnt_d = !run ? CNT_W'(`TRG_CNT_RST)
               : wr_cnt ? WDATA_I[CNT_W-1:0]
               : wrap_hit ? cnt_q - CNT_W'(1)
               : cnt_q;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  assign cfg_d = !run ? `TRG_CFG_RST
               : wr_cfg ? WDATA_I[`TRG_CFG_W-1:0]
               : cfg_q;

  assign wrap_d = !run ? PRE_W'(`TRG_WRAP_RST)
                : wr_wrap ? WDATA_I[PRE_W-1:0]
                : wrap_q;

  // ----------------------------------------
  // Chip reset sequencing
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    pulse_d = pulse_q;
    case (state_q)
      TRG_ST_RUN:
      begin
        if (fire)
        begin
          state_d = TRG_ST_HOLD;
          pulse_d = PULSE_W'(`TRG_PULSE_LEN - 8'h01);
        end
      end
      TRG_ST_HOLD:
      begin
        if (pulse_done)
          state_d = TRG_ST_RUN;
        else
          pulse_d = pulse_q - PULSE_W'(1);
      end
      default:
      begin
        state_d = TRG_ST_RUN;
        pulse_d = PULSE_W'(0);
      end
    endcase
  end

  assign fired_d = fired_q | fire;

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  assign ev[`TRG_EV_ZERO_BIT] = wrap_hit && !wr_cnt && (cnt_q == CNT_W'(1));
  assign ev[`TRG_EV_RST_BIT] = fire;

  genvar gi;
  generate
    for (gi = 0; gi < `TRG_EV_NUM; gi++)
    begin : g_ist
      assign ist_d[gi] = ev[gi] | (ist_q[gi] & ~(wr_ist & WDATA_I[gi]));
    end
  endgenerate

  assign imask_d = wr_imask ? WDATA_I[`TRG_EV_NUM-1:0] : imask_q;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  assign rd_mux =
      hit(ADDR_I, `TRG_OFF_CFG) ? 32'(cfg_q)
    : hit(ADDR_I, `TRG_OFF_PRE) ? 32'(pre_q)
    : hit(ADDR_I, `TRG_OFF_WRAP) ? 32'(wrap_q)
    : hit(ADDR_I, `TRG_OFF_CNT) ? 32'(cnt_q)
    : hit(ADDR_I, `TRG_OFF_STAT) ? 32'(fired_q)
    : hit(ADDR_I, `TRG_OFF_ISTAT) ? 32'(ist_q)
    : hit(ADDR_I, `TRG_OFF_IMASK) ? 32'(imask_q)
    : `TRG_DATA_ZERO;

  assign rdata_d = RD_I ? rd_mux : `TRG_DATA_ZERO;

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cfg_q <= `TRG_CFG_RST;
      pre_q <= PRE_W'(`TRG_PRE_RST);
      wrap_q <= PRE_W'(`TRG_WRAP_RST);
      cnt_q <= CNT_W'(`TRG_CNT_RST);
    end
    else if (CE_I)
    begin
      cfg_q <= cfg_d;
      pre_q <= pre_d;
      wrap_q <= wrap_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_q <= TRG_ST_RUN;
      pulse_q <= PULSE_W'(0);
      fired_q <= 1'b0;
    end
    else if (CE_I)
    begin
      state_q <= state_d;
      pulse_q <= pulse_d;
      fired_q <= fired_d;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ist_q <= '0;
      imask_q <= '0;
      rdata_q <= `TRG_DATA_ZERO;
    end
    else if (CE_I)
    begin
      ist_q <= ist_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RDATA_O = rdata_q;
  assign CHIP_RST_O = (state_q == TRG_ST_HOLD);
  assign IRQ_O = |(ist_q & imask_q);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  AST_IDLE_AFTER_RESET: assert property (
    CE_I && run && !count_en && !wr_cnt |=> $stable(cnt_q)
  ) else $error("Timeout counter moved while counting disabled");

  AST_TRIGGER_NEEDS_ENABLE: assert property (
    $rose(CHIP_RST_O) |-> $past(trig_en) && $past(cnt_zero)
  ) else $error("Chip reset without trigger enable at zero");

  AST_COUNT_DECREMENTS: assert property (
    CE_I && wrap_hit && !wr_cnt |=> cnt_q == $past(cnt_q) - CNT_W'(1)
  ) else $error("Counter did not decrement on prescaler wrap");

  AST_DEBUG_NO_RESET: assert property (
    run && !trig_en ##1 1'b1 |-> !$rose(CHIP_RST_O)
  ) else $error("Chip reset raised with trigger disabled");

  AST_PRESCALE_ADVANCES: assert property (
    CE_I && run && count_en && !wrap_hit |=> pre_q == $past(pre_q) + PRE_W'(1)
  ) else $error("Prescaler failed to advance");

  AST_PRESCALE_WRAPS: assert property (
    CE_I && wrap_hit |=> pre_q == PRE_W'(0)
  ) else $error("Prescaler failed to return to zero");

  AST_PRESCALE_TWO_EDGES: assert property (
    (CE_I && run && count_en && !wrap_hit && !wr_wrap && !wr_cfg
      && !(pre_q + PRE_W'(1) == wrap_q)) ##1 CE_I && run
      |=> pre_q == $past(pre_q, 2) + PRE_W'(2)
  ) else $error("Prescaler not counting every oscillator edge");

  AST_DIVIDE_BY_ONE: assert property (
    CE_I && wrap_hit && wrap_q == PRE_W'(0) && !wr_wrap
      && !wr_cfg ##1 CE_I && run |-> wrap_hit
  ) else $error("Zero wrap value did not divide by one");

  AST_COUNT_WRITE: assert property (
    CE_I && run && wr_cnt |=> cnt_q == $past(WDATA_I[CNT_W-1:0])
  ) else $error("Timeout counter write not taken");

  AST_ZERO_FIRES: assert property (
    CE_I && fire |=> CHIP_RST_O && fired_q
  ) else $error("Zero count with trigger did not reset the chip");

  AST_FIRED_STICKY: assert property (
    fired_q |=> fired_q
  ) else $error("Fired flag cleared without power-on reset");

  AST_HOLD_PRESCALE: assert property (
    CE_I && run && !count_en |=> $stable(pre_q) && !$rose(CHIP_RST_O)
  ) else $error("Prescaler moved or reset raised while disabled");

  AST_CE_FREEZE_COUNT: assert property (
    !CE_I |=> $stable(pre_q) && $stable(cnt_q) && $stable(CHIP_RST_O)
  ) else $error("Counters moved while clock enable low");

  AST_CE_FREEZE_REGS: assert property (
    !CE_I |=> $stable(cfg_q) && $stable(wrap_q) && $stable(fired_q)
  ) else $error("Registers moved while clock enable low");

  AST_CFG_WRITE: assert property (
    CE_I && run && wr_cfg |=> cfg_q == $past(WDATA_I[`TRG_CFG_W-1:0])
  ) else $error("Config write not taken");

  AST_WRAP_WRITE: assert property (
    CE_I && run && wr_wrap |=> wrap_q == $past(WDATA_I[PRE_W-1:0])
  ) else $error("Wrap write not taken");

  AST_COUNT_ONLY_ON_WRAP: assert property (
    CE_I && run && !wrap_hit && !wr_cnt |=> $stable(cnt_q)
  ) else $error("Timeout counter moved between prescaler wraps");

  AST_PULSE_START: assert property (
    $rose(CHIP_RST_O) |-> pulse_q == PULSE_W'(`TRG_PULSE_LEN - 8'h01)
  ) else $error("Chip reset pulse loaded with wrong length");

  AST_PULSE_STEPS: assert property (
    CE_I && CHIP_RST_O && !pulse_done
      |=> CHIP_RST_O && pulse_q == $past(pulse_q) - PULSE_W'(1)
  ) else $error("Chip reset pulse did not count down");

  AST_PULSE_ENDS: assert property (
    CE_I && CHIP_RST_O && pulse_done |=> !CHIP_RST_O
  ) else $error("Chip reset pulse did not end");

  AST_RESET_RELOADS: assert property (
    CE_I && CHIP_RST_O
      |=> cfg_q == `TRG_CFG_RST && cnt_q == CNT_W'(`TRG_CNT_RST)
  ) else $error("Chip reset did not reload config and counter");

  AST_RESET_PRESCALE: assert property (
    CE_I && CHIP_RST_O
      |=> pre_q == PRE_W'(`TRG_PRE_RST) && wrap_q == PRE_W'(`TRG_WRAP_RST)
  ) else $error("Chip reset did not reload prescaler and wrap");

  AST_FIRED_SURVIVES: assert property (
    CE_I && CHIP_RST_O |=> fired_q
  ) else $error("Fired flag lost during chip reset");

  AST_STATUS_READ: assert property (
    CE_I && RD_I && hit(ADDR_I, `TRG_OFF_STAT)
      |=> RDATA_O == 32'($past(fired_q))
  ) else $error("Status read returned wrong value");

  AST_PRESCALE_READ: assert property (
    CE_I && RD_I && hit(ADDR_I, `TRG_OFF_PRE)
      |=> RDATA_O == 32'($past(pre_q))
  ) else $error("Prescaler read returned wrong value");

  AST_COUNT_READ: assert property (
    CE_I && RD_I && hit(ADDR_I, `TRG_OFF_CNT)
      |=> RDATA_O == 32'($past(cnt_q))
  ) else $error("Counter read returned wrong value");

  AST_DEBUG_AT_ZERO: assert property (
    CE_I && run && count_en && !trig_en && cnt_zero |=> !CHIP_RST_O
  ) else $error("Chip reset raised at zero in debug mode");

  AST_DISABLED_NO_RESET: assert property (
    CE_I && run && !count_en |=> !CHIP_RST_O
  ) else $error("Chip reset raised while counting disabled");

  AST_ZERO_EVENT: assert property (
    CE_I && ev[`TRG_EV_ZERO_BIT] |=> ist_q[`TRG_EV_ZERO_BIT]
  ) else $error("Counter zero event not recorded");

  AST_FIRE_EVENT: assert property (
    CE_I && fire |=> ist_q[`TRG_EV_RST_BIT]
  ) else $error("Chip reset event not recorded");

endmodule : trg_timeout_reset_guard

// file: tb/tb_timeout_reset_guard.sv
// Self-checking bench of the timeout reset guard.
// Assumes the guard package and constants header on the include path.
`timescale 1ns/1ps
`include "trg_consts.svh"

module tb_timeout_reset_guard;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic clk, rst, ce, wr_s, rd_s, chip_rst, irq, allow_rst;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] ep, wrap;
  logic [11:0] ec;
  int seed = 32'h9148;
  int fail_count = 0;
  int comparisons = 0;
  int i, n;

  trg_timeout_reset_guard u_dut (
    .REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
    .CHIP_RST_O(chip_rst), .IRQ_O(irq));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task wr(input logic [15:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr

  task rd_chk(input logic [15:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    check(rdata, e);
    @(posedge clk);
  endtask : rd_chk

  // Count for k cycles, then model the prescaler and counter
  task run_count(input logic [15:0] w, input logic [11:0] c, input int k);
    int m;
    m = 0;
    wr(`TRG_OFF_WRAP, {16'h0000, w});
    wr(`TRG_OFF_CNT, {20'h00000, c});
    wr(`TRG_OFF_CFG, 32'h0000_0001);
    repeat (k)
    begin
      ce <= ($random(seed) & 3) != 0;
      @(posedge clk);
      m = m + ce;
    end
    ce <= 1'b1;
    wr(`TRG_OFF_CFG, 32'h0000_0000);
    ec = c;
    for (int j = 0; j < m + 2; j++)
      if (ep == w)
      begin
        ep = 16'h0000;
        ec = ec - 12'h001;
      end
      else
        ep = ep + 16'h0001;
    rd_chk(`TRG_OFF_PRE, {16'h0000, ep});
    rd_chk(`TRG_OFF_CNT, {20'h00000, ec});
    rd_chk(`TRG_OFF_PRE, {16'h0000, ep});
  endtask : run_count

  // ----------------------------------------
  // Monitor and watchdog
  // ----------------------------------------
  always @(negedge clk)
    if (!allow_rst && !rst)
      check({31'h0, chip_rst}, 32'h0000_0000);

  initial
  begin
    #200000;
    fail_count++;
    end_sim;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 16'h0000;
    wdata = 32'h0000_0000;
    allow_rst = 1'b0;
    ep = 16'h0000;
    ce = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    rd_chk(`TRG_OFF_CFG, 32'h0000_0000);
    rd_chk(`TRG_OFF_PRE, 32'h0000_0000);
    rd_chk(`TRG_OFF_WRAP, 32'h0000_FFFF);
    rd_chk(`TRG_OFF_CNT, 32'h0000_0FFF);
    rd_chk(`TRG_OFF_STAT, 32'h0000_0000);
    rd_chk(`TRG_OFF_ISTAT, 32'h0000_0000);
    rd_chk(`TRG_OFF_IMASK, 32'h0000_0000);
    rd_chk(16'hF030, 32'h0000_0000);
    wr(`TRG_OFF_PRE, $random(seed));
    wr(`TRG_OFF_STAT, 32'h0000_0001);
    rd_chk(`TRG_OFF_PRE, 32'h0000_0000);
    rd_chk(`TRG_OFF_STAT, 32'h0000_0000);
    wr(`TRG_OFF_CFG, 32'h0000_0003);
    rd_chk(`TRG_OFF_CFG, 32'h0000_0003);
    wr(`TRG_OFF_CFG, 32'h0000_0000);
    ep = 16'h0004;
    // Debug mode: counter passes zero and wraps with no chip reset
    run_count(16'h0004, 12'h002, 30);
    rd_chk(`TRG_OFF_ISTAT, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    @(posedge clk);
    wr(`TRG_OFF_IMASK, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    @(posedge clk);
    wr(`TRG_OFF_ISTAT, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    @(posedge clk);
    for (i = 0; i < 4; i++)
    begin
      wrap = ep + 16'(2 * i + 1) + 16'($unsigned($random(seed)) % 2);
      n = 10 + $unsigned($random(seed)) % 50;
      run_count(wrap, 12'($random(seed)), n);
    end
    // Timeout with trigger enabled
    wr(`TRG_OFF_IMASK, 32'h0000_0002);
    wr(`TRG_OFF_WRAP, {16'h0000, ep});
    wr(`TRG_OFF_CNT, 32'h0000_0001);
    allow_rst = 1'b1;
    wr(`TRG_OFF_CFG, 32'h0000_0003);
    repeat (1) @(posedge clk);
    repeat (16)
    begin
      @(negedge clk);
      check({31'h0, chip_rst}, 32'h0000_0001);
      @(posedge clk);
    end
    @(negedge clk);
    check({31'h0, chip_rst}, 32'h0000_0000);
    allow_rst = 1'b0;
    check({31'h0, irq}, 32'h0000_0001);
    @(posedge clk);
    rd_chk(`TRG_OFF_STAT, 32'h0000_0001);
    rd_chk(`TRG_OFF_CFG, 32'h0000_0000);
    rd_chk(`TRG_OFF_CNT, 32'h0000_0FFF);
    rd_chk(`TRG_OFF_ISTAT, 32'h0000_0003);
    rd_chk(`TRG_OFF_WRAP, 32'h0000_FFFF);
    rd_chk(`TRG_OFF_PRE, 32'h0000_0000);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(`TRG_OFF_STAT, 32'h0000_0000);
    // Zero wrap value: one decrement on every enabled edge
    ep = 16'h0000;
    run_count(16'h0000, 12'($random(seed)), 8);
    end_sim;
  end
endmodule : tb_timeout_reset_guard
